/* shared/uart_tx_params.svh */
// constants for the serial transmitter: offsets, fields, reset values
`ifndef UART_TX_PARAMS_SVH
`define UART_TX_PARAMS_SVH
`define MODE_OFS       12'h000
`define STATUS_OFS     12'h004
`define TXDATA_OFS     12'h008
`define BAUD_OFS       12'h00c
`define PORT_OFS       12'h010
`define MODE_ON_BIT    15
`define MODE_ALT_BIT   10
`define MODE_STOP_BIT  0
`define MODE_FMT_LO    1
`define STA_TXISEL_BIT 15
`define STA_TXEN_BIT   10
`define STA_FULL_BIT   9
`define STA_BRK_BIT    11
`define STA_SHIFTER_EMPTY_FLAG_BIT   8
`define STA_RECEIVER_IDLE_FLAG_BIT  4
`define STA_ADDRESS_DETECT_ENABLE_BIT  5
`define STA_RXISEL_LO  6
`define FMT_8N         2'h0
`define FMT_8E         2'h1
`define FMT_8O         2'h2
`define FMT_9N         2'h3
`define MODE_RESET     16'h0000
`define BAUD_RESET     16'h0000
`define QUEUE_DEPTH    4
`define QUEUE_WIDTH    9
`define PORT_OE_BIT    3
`define PORT_LAT_BIT   2
`define PORT_RXOE_BIT  1
`define PORT_RESET     4'h0
`endif

/* shared/uart_tx_pkg.sv */
// types shared by the serial transmitter
package uart_tx_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_e;
  // port pin control seen from the port block
  typedef struct packed {
    logic out_val;
    logic out_en;
  } pin_drive_s;
endpackage

/* verilog/uart_tx.sv */
// serial transmitter with enable, pin ownership, format select and queue
`timescale 1ns/1ps
`include "uart_tx_params.svh"
// ----------------------------------------------------------------
// What this block does
// - module on drives out pin, in pin input
// - idle transmit line held high
// - reset disables; pins follow port latch/direction
// - disable empties buffers, resets baud counter
// - disable clears flags, sets idle/empty flags
// - disable keeps configuration registers unchanged
// - disable aborts activity; reenable keeps config
// - alternate bit selects alternate pin pair
// - format field picks data width and parity
// - stop select gives one or two stops
// - power on format is 8N1
// - transmit only with transmit enable set
// - written byte loads empty shifter immediately
// - enable after write starts output immediately
// - transmit interrupt follows select bit
// - queue four deep, nine wide, plus shifter
// - full flag shows queue cannot accept
// - write to full queue is discarded
// - queue cleared by reset or disable
// ----------------------------------------------------------------
module uart_tx #(
  parameter int DEPTH = `QUEUE_DEPTH,
  parameter int WIDTH = `QUEUE_WIDTH
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // primary pins
  output logic             serial_out_pin_o,
  output logic             serial_out_pin_oe,
  input  wire logic        serial_in_pin,
  output logic             serial_in_pin_oe,
  // alternate pins
  output logic             alt_serial_out_pin_o,
  output logic             alt_serial_out_pin_oe,
  input  wire logic        alt_serial_in_pin,
  output logic             alt_serial_in_pin_oe,
  // receive line as seen by the (absent) receiver
  output logic             rx_line,
  // transmit interrupt request
  output logic             tx_irq
);
  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic [11:0] addr_r;           // latched address phase
  logic        wr_r;             // pending write
  logic        rd_r;             // pending read
  logic        ap_valid;         // address phase accepted
  assign ap_valid  = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;       // zero wait states
  assign hresp     = 1'b0;

  // address phase capture
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= 12'h000;
      wr_r   <= 1'b0;
      rd_r   <= 1'b0;
    end else begin
      addr_r <= haddr;
      wr_r   <= ap_valid && hwrite;
      rd_r   <= ap_valid && !hwrite;
    end
  end

  // decode helper, used for write and read paths
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a[11:2] == ofs[11:2]);
  endfunction

  logic wr_mode, wr_sta, wr_tx, wr_baud, wr_port;
  assign wr_mode = wr_r && hit(addr_r, `MODE_OFS);
  assign wr_sta  = wr_r && hit(addr_r, `STATUS_OFS);
  assign wr_tx   = wr_r && hit(addr_r, `TXDATA_OFS);
  assign wr_baud = wr_r && hit(addr_r, `BAUD_OFS);
  assign wr_port = wr_r && hit(addr_r, `PORT_OFS);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [15:0] mode_r;           // serial_mode_reg
  logic [15:0] baud_r;           // baud_divisor_reg
  logic        txen_r;           // transmit_enable_bit
  logic        brk_r;            // send_break_bit
  logic        txisel_r;         // tx_irq_select
  logic        address_detect_enable_r;          // address_detect_enable
  logic [1:0]  rxisel_r;         // rx_irq_select
  logic [3:0]  port_r;           // {dir_tx, lat_tx, dir_rx, lat_rx} port bits
  logic        module_on;
  logic        alt_sel;
  logic [1:0]  fmt;
  logic        two_stop;
  assign module_on = mode_r[`MODE_ON_BIT];
  assign alt_sel   = mode_r[`MODE_ALT_BIT];
  assign fmt       = mode_r[`MODE_FMT_LO+1:`MODE_FMT_LO];
  assign two_stop  = mode_r[`MODE_STOP_BIT];

  // mode and divisor are untouched by disable; reset gives 8N1 off
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= `MODE_RESET;
      baud_r <= `BAUD_RESET;
      port_r <= `PORT_RESET;
    end else begin
      if (wr_mode) mode_r <= hwdata[15:0];
      if (wr_baud) baud_r <= hwdata[15:0];
      if (wr_port) port_r <= hwdata[3:0];
    end
  end

  // status control bits; disable clears enable and break only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      txen_r   <= 1'b0;
      brk_r    <= 1'b0;
      txisel_r <= 1'b0;
      address_detect_enable_r  <= 1'b0;
      rxisel_r <= 2'h0;
    end else begin
      if (wr_sta) begin
        txisel_r <= hwdata[`STA_TXISEL_BIT];
        address_detect_enable_r  <= hwdata[`STA_ADDRESS_DETECT_ENABLE_BIT];
        rxisel_r <= hwdata[`STA_RXISEL_LO+1:`STA_RXISEL_LO];
      end
      if (!module_on) begin
        txen_r <= 1'b0;
        brk_r  <= 1'b0;
      end else if (wr_sta) begin
        txen_r <= hwdata[`STA_TXEN_BIT];
        brk_r  <= hwdata[`STA_BRK_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit queue
  // ----------------------------------------------------------------
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] q_mem [DEPTH];
  logic [PW-1:0]    q_wp, q_rp;
  logic [PW:0]      q_cnt;
  logic             q_full, q_empty, q_push, q_pop;
  assign q_full  = (q_cnt == (PW+1)'(DEPTH));
  assign q_empty = (q_cnt == '0);
  assign q_push  = wr_tx && module_on && !q_full;

  // queue storage; only disable or reset empties it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q_wp  <= '0;
      q_rp  <= '0;
      q_cnt <= '0;
    end else if (!module_on) begin
      q_wp  <= '0;
      q_rp  <= '0;
      q_cnt <= '0;
    end else begin
      if (q_push) q_wp <= PW'((q_wp + 1'b1) % DEPTH);
      if (q_pop)  q_rp <= PW'((q_rp + 1'b1) % DEPTH);
      q_cnt <= q_cnt + (PW+1)'(q_push) - (PW+1)'(q_pop);
    end
  end

  // storage without reset; pointers define validity
  always_ff @(posedge clock) begin
    if (q_push) q_mem[q_wp] <= hwdata[WIDTH-1:0];
  end

  // ----------------------------------------------------------------
  // baud tick
  // ----------------------------------------------------------------
  logic [15:0] baud_cnt_r;
  logic        tick;
  logic        run;
  assign tick = (baud_cnt_r == 16'h0000);
  assign run  = module_on && txen_r;

  // counter held cleared until the transmitter runs, so first tick is instant
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) baud_cnt_r <= 16'h0000;
    else if (!run) baud_cnt_r <= 16'h0000;
    else if (tick) baud_cnt_r <= baud_r;
    else baud_cnt_r <= baud_cnt_r - 16'h0001;
  end

  // ----------------------------------------------------------------
  // shifter
  // ----------------------------------------------------------------
  uart_tx_pkg::tx_state_e st_r;
  logic [8:0] sh_r;              // tx_shift_reg
  logic       sh_full_r;         // shifter holds a character
  logic [3:0] bit_r;             // bit counter
  logic       par_r;             // running parity
  logic       line_r;            // serial line value
  logic [3:0] nbits;
  assign nbits = (fmt == `FMT_9N) ? 4'h9 : 4'h8;
  // shifter loads from queue when it is empty, even with transmit off
  assign q_pop = module_on && !sh_full_r && !q_empty;

  // frame sequencer, advances on baud ticks
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= uart_tx_pkg::TX_IDLE;
      sh_r <= 9'h000;
      sh_full_r <= 1'b0;
      bit_r <= 4'h0;
      par_r <= 1'b0;
      line_r <= 1'b1;
    end else if (!module_on) begin
      st_r <= uart_tx_pkg::TX_IDLE;
      sh_full_r <= 1'b0;
      line_r <= 1'b1;
    end else begin
      if (q_pop) begin
        sh_r <= q_mem[q_rp];
        sh_full_r <= 1'b1;
      end
      if (run && tick) begin
        unique case (st_r)
          uart_tx_pkg::TX_IDLE: if (sh_full_r) begin
            line_r <= 1'b0;
            st_r <= uart_tx_pkg::TX_START;
            bit_r <= 4'h0;
            par_r <= (fmt == `FMT_8O);
          end
          uart_tx_pkg::TX_START, uart_tx_pkg::TX_DATA: begin
            line_r <= sh_r[bit_r];
            par_r <= par_r ^ sh_r[bit_r];
            bit_r <= bit_r + 4'h1;
            st_r <= (bit_r + 4'h1 == nbits) ?
                    ((fmt == `FMT_8E || fmt == `FMT_8O) ? uart_tx_pkg::TX_PARITY
                                                        : uart_tx_pkg::TX_STOP)
                    : uart_tx_pkg::TX_DATA;
            if (bit_r + 4'h1 == nbits && !(fmt == `FMT_8E || fmt == `FMT_8O))
              bit_r <= 4'h0;
          end
          uart_tx_pkg::TX_PARITY: begin
            line_r <= par_r;
            st_r <= uart_tx_pkg::TX_STOP;
            bit_r <= 4'h0;
          end
          uart_tx_pkg::TX_STOP: begin
            line_r <= 1'b1;
            bit_r <= bit_r + 4'h1;
            if (bit_r == {3'h0, two_stop}) begin
              st_r <= uart_tx_pkg::TX_IDLE;
              sh_full_r <= q_pop;
            end
          end
        endcase
      end
    end
  end

  logic shifter_empty_flag;
  assign shifter_empty_flag = !sh_full_r && (st_r == uart_tx_pkg::TX_IDLE);

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  logic tx_val;
  assign tx_val = brk_r ? 1'b0 : line_r;
  uart_tx_pkg::pin_drive_s port_tx, own_tx;
  assign port_tx = '{out_val: port_r[`PORT_LAT_BIT], out_en: port_r[`PORT_OE_BIT]};
  assign own_tx  = '{out_val: tx_val, out_en: 1'b1};

  // pin ownership: module overrides port direction and latch
  always_comb begin
    serial_out_pin_o      = port_r[`PORT_LAT_BIT];
    serial_out_pin_oe     = port_r[`PORT_OE_BIT];
    alt_serial_out_pin_o  = port_r[`PORT_LAT_BIT];
    alt_serial_out_pin_oe = port_r[`PORT_OE_BIT];
    serial_in_pin_oe      = port_r[`PORT_RXOE_BIT];
    alt_serial_in_pin_oe  = port_r[`PORT_RXOE_BIT];
    rx_line               = 1'b1;
    if (module_on) begin
      if (alt_sel) begin
        alt_serial_out_pin_o  = own_tx.out_val;
        alt_serial_out_pin_oe = own_tx.out_en;
        alt_serial_in_pin_oe  = 1'b0;
        rx_line               = alt_serial_in_pin;
      end else begin
        serial_out_pin_o  = own_tx.out_val;
        serial_out_pin_oe = own_tx.out_en;
        serial_in_pin_oe  = 1'b0;
        rx_line           = serial_in_pin;
      end
    end else begin
      serial_out_pin_o  = port_tx.out_val;
      serial_out_pin_oe = port_tx.out_en;
    end
  end

  // transmit interrupt: select 0 on queue slot free, 1 on shifter empty
  assign tx_irq = module_on && txen_r && (txisel_r ? shifter_empty_flag : !q_full);

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [15:0] sta_view;
  always_comb begin
    sta_view = 16'h0000;
    sta_view[`STA_TXISEL_BIT] = txisel_r;
    sta_view[`STA_BRK_BIT]    = brk_r;
    sta_view[`STA_TXEN_BIT]   = txen_r;
    sta_view[`STA_FULL_BIT]   = module_on && q_full;
    sta_view[`STA_SHIFTER_EMPTY_FLAG_BIT]   = shifter_empty_flag;
    sta_view[`STA_RXISEL_LO+1:`STA_RXISEL_LO] = rxisel_r;
    sta_view[`STA_ADDRESS_DETECT_ENABLE_BIT]  = address_detect_enable_r;
    sta_view[`STA_RECEIVER_IDLE_FLAG_BIT]  = 1'b1;
  end

  // read data muxed from the registers while the data phase stands
  always_comb begin
    hrdata = 32'h0000_0000;
    if (rd_r) begin
      if (hit(addr_r, `MODE_OFS))   hrdata = {16'h0000, mode_r};
      if (hit(addr_r, `STATUS_OFS)) hrdata = {16'h0000, sta_view};
      if (hit(addr_r, `BAUD_OFS))   hrdata = {16'h0000, baud_r};
      if (hit(addr_r, `PORT_OFS))   hrdata = {28'h0000000, port_r};
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  idle_high_a: assert property (@(posedge clock) disable iff (!rst_n)
    (module_on && !brk_r && st_r == uart_tx_pkg::TX_IDLE && !alt_sel)
      |-> serial_out_pin_o && serial_out_pin_oe) else $error("idle line not high");
  full_drop_a: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_tx && q_full && !q_pop) |=> $stable(q_cnt)) else $error("full write taken");
  off_empty_a: assert property (@(posedge clock) disable iff (!rst_n)
    !module_on |=> q_cnt == '0 && !sh_full_r) else $error("disable kept data");
  // a disable may still send the sequencer home, so only an enabled module is held
  no_tx_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!txen_r && module_on) |=> $stable(st_r)) else $error("sent while disabled");
  off_flags_a: assert property (@(posedge clock) disable iff (!rst_n)
    !module_on |=> !txen_r && !brk_r) else $error("flags kept on disable");
  load_now_a: assert property (@(posedge clock) disable iff (!rst_n)
    (q_push && q_empty && !sh_full_r) |=> ##1 sh_full_r) else $error("no load");
  start_now_a: assert property (@(posedge clock) disable iff (!rst_n)
    (run && tick && sh_full_r && st_r == uart_tx_pkg::TX_IDLE) |=> !line_r)
    else $error("no start bit");
  cnt_max_a: assert property (@(posedge clock) disable iff (!rst_n)
    q_cnt <= (PW+1)'(DEPTH)) else $error("queue overfilled");
  frame_c: cover property (@(posedge clock) disable iff (!rst_n)
    st_r == uart_tx_pkg::TX_STOP ##1 st_r == uart_tx_pkg::TX_IDLE);
  full_c: cover property (@(posedge clock) disable iff (!rst_n) q_full);
  par_c: cover property (@(posedge clock) disable iff (!rst_n)
    st_r == uart_tx_pkg::TX_PARITY);
endmodule // uart_tx

/* testbench/serial_peer.sv */
// remote serial peer: samples frames seen on the device's transmit line
`timescale 1ns/1ps
module serial_peer #(
  parameter int BIT_CLKS = 4  // clocks per bit, divisor plus one
) (
  // clock
  input  wire logic        clock,
  // line under watch and expected frame length
  input  wire logic        line,
  input  wire logic [3:0]  nbits,
  // last captured frame and frame count
  output logic      [15:0] frame,
  output int               n_frames,
  // receive lines towards the device
  output logic             rx_pri,
  output logic             rx_alt
);
  // ----------------------------------------------------------------
  // frame sampler
  // ----------------------------------------------------------------
  logic prev;  // line level at the previous falling clock edge
  // samples on the falling clock edge so design updates have settled
  initial begin
    rx_pri = 1'b1;  // peer never sends, lines rest at mark level
    rx_alt = 1'b1;
    frame = '1;
    n_frames = 0;
    prev = 1'b0;  // starts low: a line held low out of reset is no start
    forever begin
      @(negedge clock);
      if (prev === 1'b1 && line === 1'b0) begin  // falling edge is a start bit
        frame = '1;
        repeat (BIT_CLKS / 2) @(negedge clock);
        for (int i = 0; i < nbits; i++) begin
          frame[i] = line;  // lsb first, stops last
          if (i < nbits - 1) repeat (BIT_CLKS) @(negedge clock);
        end
        n_frames++;  // an aborted frame is still counted, bench allows for it
      end
      prev = line;
    end
  end
endmodule // serial_peer

/* testbench/testbench.sv */
// self-checking bench for the serial transmitter over its register bus
`timescale 1ns/1ps
`include "uart_tx_params.svh"
module testbench;
  logic        clock, rst_n, hsel, hwrite, hreadyout, hresp, tx_irq, rx_line;
  logic [11:0] haddr;      // bus address
  logic [1:0]  htrans;     // transfer kind
  logic [2:0]  hsize;      // always a word
  logic [31:0] hwdata, hrdata, rd;
  logic        so_o, so_oe, si_oe, ao_o, ao_oe, ai_oe, si, ai, alt_sel;
  logic [3:0]  nbits;      // frame length handed to the peer
  logic [15:0] frame;      // frame seen by the peer
  int          n_frames, n_errors, tests_run, cycles, n0;

  uart_tx i_dut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .serial_out_pin_o(so_o), .serial_out_pin_oe(so_oe), .serial_in_pin(si),
    .serial_in_pin_oe(si_oe), .alt_serial_out_pin_o(ao_o),
    .alt_serial_out_pin_oe(ao_oe), .alt_serial_in_pin(ai),
    .alt_serial_in_pin_oe(ai_oe), .rx_line(rx_line), .tx_irq(tx_irq));

  // peer watches whichever pin pair the test selected
  serial_peer #(.BIT_CLKS(4)) i_peer (.clock(clock),
    .line(alt_sel ? ao_o : so_o), .nbits(nbits), .frame(frame),
    .n_frames(n_frames), .rx_pri(si), .rx_alt(ai));

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // whole run needs well under two thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  // one single word transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
    #1;  // let the write land before the caller looks at pins
  endtask
  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(what, e, rd);
  endtask
  // expected line pattern: start, data lsb first, parity, stops
  function automatic logic [15:0] mk(input logic [1:0] f, input logic s,
                                      input logic [8:0] d, output logic [3:0] n);
    logic [15:0] v;
    int          k;
    v = '1;
    v[0] = 1'b0;
    k = (f == 2'h3) ? 9 : 8;
    for (int i = 0; i < k; i++) v[1+i] = d[i];
    k++;
    if (f == 2'h1 || f == 2'h2) begin  // even or odd parity
      v[k] = (f == 2'h1) ? ^d[7:0] : ~^d[7:0];
      k++;
    end
    n = 4'(k + 1 + int'(s));
    return v;
  endfunction
  task automatic wait_frames(input int n);
    int t;
    t = 0;
    while (n_frames < n && t < 2000) begin
      @(posedge clock);
      t++;
    end
    if (n_frames < n) begin
      n_errors++;
      $display("Error frame count expected %0d seen %0d", n, n_frames);
    end
  endtask
  // queue one character and compare what the peer saw
  task automatic send(input logic [1:0] f, input logic s, input logic [8:0] d);
    logic [15:0] e;
    e = mk(f, s, d, nbits);
    n0 = n_frames;
    bus(1'b1, `TXDATA_OFS, {23'h0, d});  // upper bits zero
    wait_frames(n0 + 1);
    chk("frame", {16'h0, e}, {16'h0, frame});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [8:0] d;
    rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 12'h000;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    alt_sel = 1'b0;
    nbits = 4'ha;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    // state after reset, pins under port control
    rdchk("mode", `MODE_OFS, 32'h0);
    rdchk("status", `STATUS_OFS, 32'h110);
    rdchk("unmapped", 12'h020, 32'h0);
    chk("pin oe off", 32'h0, {31'h0, so_oe});
    chk("resp okay", 32'h0, {31'h0, hresp});
    bus(1'b1, `PORT_OFS, 32'hc);
    chk("port drive", 32'h3, {30'h0, so_oe, so_o});
    $display("test reset done");
    // every format and stop count
    bus(1'b1, `BAUD_OFS, 32'h3);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, `MODE_OFS, 32'h8000 | 32'(i));
      if (i == 0) bus(1'b1, `STATUS_OFS, 32'h400);
      d = {i[2] & i[1], 8'h35 + 8'(i * 29)};
      send(2'(i >> 1), i[0], d);
    end
    chk("pins owned", 32'hb, {28'h0, so_oe, si_oe, so_o, rx_line});
    $display("test formats done");
    // alternate pin pair
    bus(1'b1, `MODE_OFS, 32'h8400);
    alt_sel = 1'b1;
    chk("alt oe", 32'h5, {29'h0, ao_oe, ai_oe, rx_line});
    send(2'h0, 1'b0, 9'h0c3);
    alt_sel = 1'b0;
    bus(1'b1, `MODE_OFS, 32'h8000);
    $display("test alternate done");
    // fill with transmitter off, then drain
    bus(1'b1, `STATUS_OFS, 32'h0);
    for (int j = 0; j < 5; j++) bus(1'b1, `TXDATA_OFS, 32'h10 + 32'(j));
    bus(1'b0, `STATUS_OFS, 32'h0);
    chk("full flag", 32'h1, {31'h0, rd[9]});
    chk("irq full", 32'h0, {31'h0, tx_irq});
    bus(1'b1, `TXDATA_OFS, 32'h99);
    n0 = n_frames;
    bus(1'b1, `STATUS_OFS, 32'h400);
    for (int t = 0; t < 6 && so_o !== 1'b0; t++) @(posedge clock);
    chk("start at once", 32'h0, {31'h0, so_o});
    for (int j = 0; j < 5; j++) begin
      wait_frames(n0 + j + 1);
      chk("queued", {16'h0, mk(2'h0, 1'b0, 9'h10 + 9'(j), nbits)}, {16'h0, frame});
    end
    chk("irq room", 32'h1, {31'h0, tx_irq});
    repeat (60) @(posedge clock);
    chk("no extra frame", 32'(n0 + 5), 32'(n_frames));
    $display("test queue done");
    // disable in mid frame, then resume with kept setup
    bus(1'b1, `STATUS_OFS, 32'h8c00);
    bus(1'b1, `MODE_OFS, 32'h8005);
    chk("break low", 32'h0, {31'h0, so_o});
    for (int j = 0; j < 3; j++) bus(1'b1, `TXDATA_OFS, 32'h40 + 32'(j));
    repeat (10) @(posedge clock);
    bus(1'b1, `MODE_OFS, 32'h0005);
    rdchk("status off", `STATUS_OFS, 32'h8110);
    rdchk("mode kept", `MODE_OFS, 32'h5);
    rdchk("baud kept", `BAUD_OFS, 32'h3);
    repeat (80) @(posedge clock);
    n0 = n_frames;
    bus(1'b1, `MODE_OFS, 32'h8005);
    bus(1'b1, `STATUS_OFS, 32'h8400);
    repeat (80) @(posedge clock);
    chk("no stale frames", 32'(n0), 32'(n_frames));
    send(2'h2, 1'b1, 9'h096);
    chk("irq idle", 32'h1, {31'h0, tx_irq});
    $display("test disable done");
    // reset in mid run drops whatever was queued
    bus(1'b1, `STATUS_OFS, 32'h0);
    for (int j = 0; j < 3; j++) bus(1'b1, `TXDATA_OFS, 32'h20 + 32'(j));
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    rdchk("mode reset", `MODE_OFS, 32'h0);
    rdchk("status reset", `STATUS_OFS, 32'h110);
    bus(1'b1, `PORT_OFS, 32'hc);
    repeat (40) @(posedge clock);
    n0 = n_frames;
    bus(1'b1, `MODE_OFS, 32'h8000);
    bus(1'b1, `STATUS_OFS, 32'h400);
    repeat (80) @(posedge clock);
    chk("queue reset", 32'(n0), 32'(n_frames));
    $display("test reset in run done");
    end_sim();
  end
endmodule // testbench
